// ===== include/phg_pkg.sv
package phg_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ  = 200_000_000;
	localparam int unsigned PULSE_MS     = 100;
	localparam int unsigned PULSE_CYCLES = (CLK_FREQ_HZ / 1000) * PULSE_MS;
	localparam int unsigned CNT_W        = 25;

	// ---------------------------------------------------------------
	// Answer modes
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PHG_ANS_NORMAL      = 2'h0,
		PHG_ANS_ON          = 2'h1,
		PHG_ANS_ON_OR_LISTEN = 2'h2
	} phg_answer_mode_t;

	// Active-low command pins from the hybrid, as sampled
	typedef struct packed
	{
		logic on_n;
		logic off_n;
		logic listen_n;
		logic reset_n;
		logic ready_n;
	} phg_cmd_t;

	// Open-collector lamp and pulse outputs, output enable low = pulled low (active)
	typedef struct packed
	{
		logic on_lamp_oe_n;
		logic off_lamp_oe_n;
		logic listen_lamp_oe_n;
		logic start_oe_n;
		logic stop_oe_n;
	} phg_out_t;

	localparam phg_cmd_t CMD_IDLE = 5'h1f;
	localparam phg_out_t OUT_IDLE = 5'h1f;

endpackage

// ===== rtl/phg_pulse.sv
`timescale 1ns/1ps
// One-shot pulse timer: a trigger starts (or restarts) a fixed-length pulse
module phg_pulse
	import phg_pkg::*;
#(
	parameter int unsigned LEN = PULSE_CYCLES
)
(
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic reset_n_i,
	// Control
	input  wire logic trig_i,
	output logic      busy_o
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	// Load on trigger, count down to zero
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (trig_i)
			nxt_cnt = CNT_W'(LEN);
		else if (cnt_ff != '0)
			nxt_cnt = cnt_ff - 1'b1;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	assign busy_o = (cnt_ff != '0);

endmodule

// ===== rtl/phg_gpio_ctrl.sv
`timescale 1ns/1ps
module phg_gpio_ctrl
	import phg_pkg::*;
#(
	parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             reset_n_i,
	// Console side
	input  wire phg_answer_mode_t answer_mode_i,
	input  wire logic             console_on_i,
	input  wire logic             console_off_i,
	input  wire logic             console_listen_on_i,
	input  wire logic             console_listen_off_i,
	input  wire logic             preview_select_i,
	output logic                  channel_on_o,
	output logic                  prefade_listen_o,
	// Hybrid pins
	input  wire phg_cmd_t         cmd_pins_i,
	output phg_out_t              out_pins_o
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	phg_cmd_t sync1_ff, sync2_ff, prev_ff;
	phg_cmd_t nxt_sync1, nxt_sync2, nxt_prev;

	// Two stages before use; prev_ff feeds falling-edge detection
	always_comb
	begin
		nxt_sync1 = cmd_pins_i;
		nxt_sync2 = sync1_ff;
		nxt_prev  = sync2_ff;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync1_ff <= CMD_IDLE;
			sync2_ff <= CMD_IDLE;
			prev_ff  <= CMD_IDLE;
		end
		else
		begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			prev_ff  <= nxt_prev;
		end
	end

	// Assertion edges of the active-low commands
	logic hy_on, hy_off, hy_listen, hy_reset;
	assign hy_on     = prev_ff.on_n     & ~sync2_ff.on_n;
	assign hy_off    = prev_ff.off_n    & ~sync2_ff.off_n;
	assign hy_listen = prev_ff.listen_n & ~sync2_ff.listen_n;
	assign hy_reset  = prev_ff.reset_n  & ~sync2_ff.reset_n;

	// ---------------------------------------------------------------
	// Channel state
	// ---------------------------------------------------------------
	logic on_ff, listen_ff, prev_pvw_ff, mode_ok_ff;
	logic nxt_on, nxt_listen, nxt_prev_pvw;
	logic want_on, want_off, start_trig, stop_trig, answer;

	// Mode is held in normal until out of reset; an illegal code acts as normal
	always_comb
	begin
		want_on  = hy_on | console_on_i;
		want_off = hy_off | console_off_i;
		nxt_on   = on_ff;
		nxt_listen = listen_ff;
		stop_trig  = 1'b0;
		// Reset command wins and never sends a stop pulse
		if (hy_reset)
			nxt_on = 1'b0;
		else if (want_off)
		begin
			nxt_on    = 1'b0;
			stop_trig = on_ff;
		end
		else if (want_on)
			nxt_on = 1'b1;
		if (hy_listen | console_listen_on_i)
			nxt_listen = 1'b1;
		else if (console_listen_off_i)
			nxt_listen = 1'b0;
		nxt_prev_pvw = preview_select_i;
		// Answering pulse depends on the mode
		answer = 1'b0;
		if (mode_ok_ff)
		begin
			case (answer_mode_i)
				PHG_ANS_NORMAL:       answer = 1'b0;
				PHG_ANS_ON:           answer = nxt_on & ~on_ff;
				PHG_ANS_ON_OR_LISTEN: answer = (nxt_on & ~on_ff)
				                             | (nxt_listen & ~listen_ff);
				default:              answer = 1'b0;
			endcase
		end
		// Start pulse on each new preview select as well
		start_trig = answer | (preview_select_i & ~prev_pvw_ff);
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			on_ff       <= 1'b0;
			listen_ff   <= 1'b0;
			prev_pvw_ff <= 1'b0;
			mode_ok_ff  <= 1'b0; // Normal mode during reset
		end
		else
		begin
			on_ff       <= nxt_on;
			listen_ff   <= nxt_listen;
			prev_pvw_ff <= nxt_prev_pvw;
			mode_ok_ff  <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Pulse timers
	// ---------------------------------------------------------------
	logic start_busy, stop_busy;

	// Both timers count system clocks, so the width follows PULSE_LEN
	phg_pulse #(.LEN(PULSE_LEN)) u_start
	(
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.trig_i    (start_trig),
		.busy_o    (start_busy)
	);

	phg_pulse #(.LEN(PULSE_LEN)) u_stop
	(
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.trig_i    (stop_trig),
		.busy_o    (stop_busy)
	);

	// ---------------------------------------------------------------
	// Outputs, all registered
	// ---------------------------------------------------------------
	phg_out_t out_ff, nxt_out;

	// Lamps follow state; ready also lights off lamp
	always_comb
	begin
		nxt_out.on_lamp_oe_n     = ~on_ff;
		nxt_out.off_lamp_oe_n    = ~(~on_ff | ~sync2_ff.ready_n);
		nxt_out.listen_lamp_oe_n = ~listen_ff;
		nxt_out.start_oe_n       = ~start_busy;
		nxt_out.stop_oe_n        = ~stop_busy;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			out_ff           <= OUT_IDLE;
			channel_on_o     <= 1'b0;
			prefade_listen_o <= 1'b0;
		end
		else
		begin
			out_ff           <= nxt_out;
			channel_on_o     <= on_ff;
			prefade_listen_o <= listen_ff;
		end
	end

	assign out_pins_o = out_ff;

endmodule

// ===== dv/phg_gpio_ctrl_monitor.sv
`timescale 1ns/1ps
module phg_chk
	import phg_pkg::*;
#(
	parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
	// Observed ports
	input wire logic             sys_clk_i,
	input wire logic             reset_n_i,
	input wire phg_answer_mode_t answer_mode_i,
	input wire logic             preview_select_i,
	input wire logic             channel_on_o,
	input wire logic             prefade_listen_o,
	input wire phg_cmd_t         cmd_pins_i,
	input wire phg_out_t         out_pins_o
);
	// ----------------------------------------
	// Stop pulse width counter
	// ----------------------------------------
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	always_comb nxt_cnt = out_pins_o.stop_oe_n ? 32'h0 : cnt_ff + 32'h1;
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
		if (!reset_n_i) cnt_ff <= 32'h0;
		else cnt_ff <= nxt_cnt;
	// Start pulse width counter
	logic [31:0] scnt_ff;
	logic [31:0] nxt_scnt;
	always_comb nxt_scnt = out_pins_o.start_oe_n ? 32'h0 : scnt_ff + 32'h1;
	always_ff @(posedge sys_clk_i or negedge reset_n_i)
		if (!reset_n_i) scnt_ff <= 32'h0;
		else scnt_ff <= nxt_scnt;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	on_lamp_a: assert property (out_pins_o.on_lamp_oe_n == !channel_on_o)
		else $error("on lamp wrong");
	off_lamp_a: assert property (!channel_on_o[*3] |-> !out_pins_o.off_lamp_oe_n)
		else $error("off lamp wrong");
	listen_lamp_a: assert property (out_pins_o.listen_lamp_oe_n == !prefade_listen_o)
		else $error("listen lamp wrong");
	ready_lamp_a: assert property (!cmd_pins_i.ready_n[*5] |-> !out_pins_o.off_lamp_oe_n)
		else $error("ready lamp wrong");
	stop_len_a: assert property ($rose(out_pins_o.stop_oe_n) |-> cnt_ff == PULSE_LEN)
		else $error("stop width wrong");
	start_len_a: assert property ($rose(out_pins_o.start_oe_n) |-> scnt_ff == PULSE_LEN)
		else $error("start width wrong");
	stop_cause_a: assert property ($fell(out_pins_o.stop_oe_n) |-> $fell(channel_on_o))
		else $error("stop without off");
	normal_start_a: assert property ($fell(out_pins_o.start_oe_n)
		&& answer_mode_i == PHG_ANS_NORMAL |-> preview_select_i) else $error("normal answered");
	on_answer_a: assert property ($rose(channel_on_o)
		&& answer_mode_i == PHG_ANS_ON |-> !out_pins_o.start_oe_n) else $error("no answer");
	listen_answer_a: assert property ($rose(prefade_listen_o)
		&& answer_mode_i == PHG_ANS_ON_OR_LISTEN |-> !out_pins_o.start_oe_n)
		else $error("no listen answer");
endmodule
bind phg_gpio_ctrl phg_chk #(.PULSE_LEN(PULSE_LEN)) u_phg_chk (.sys_clk_i(sys_clk_i),
	.reset_n_i(reset_n_i), .answer_mode_i(answer_mode_i), .preview_select_i(preview_select_i),
	.channel_on_o(channel_on_o), .prefade_listen_o(prefade_listen_o),
	.cmd_pins_i(cmd_pins_i), .out_pins_o(out_pins_o));

// ===== dv/phg_hybrid_model.sv
`timescale 1ns/1ps
module phg_hybrid_model
	import phg_pkg::*;
(
	// Bench control and lamp side
	input  wire logic     [4:0] press_i,
	input  wire phg_out_t       out_pins_i,
	// Command pins and pulse tallies
	output phg_cmd_t            cmd_pins_o,
	output int                  starts_o,
	output int                  stops_o
);
	// Contacts pull their line low; pull-ups idle them high
	assign cmd_pins_o = phg_cmd_t'(~press_i);
	initial starts_o = 0;
	initial stops_o = 0;
	// Tally each pulse at its leading edge
	always @(negedge out_pins_i.start_oe_n) starts_o++;
	always @(negedge out_pins_i.stop_oe_n) stops_o++;
endmodule

// ===== dv/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
	import phg_pkg::*;
	localparam int unsigned LEN = 10;
	logic             sys_clk_i, reset_n_i, prev, chan, lis;
	logic       [3:0] con;
	logic       [4:0] press;
	phg_answer_mode_t mode;
	phg_cmd_t         cmd;
	phg_out_t         outp;
	int               starts, stops, errors, compares;
	phg_gpio_ctrl #(.PULSE_LEN(LEN)) u_phg_gpio_ctrl (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .answer_mode_i(mode), .console_on_i(con[0]),
		.console_off_i(con[1]), .console_listen_on_i(con[2]), .console_listen_off_i(con[3]),
		.preview_select_i(prev), .channel_on_o(chan), .prefade_listen_o(lis),
		.cmd_pins_i(cmd), .out_pins_o(outp));
	phg_hybrid_model u_phg_hybrid_model (.press_i(press), .out_pins_i(outp),
		.cmd_pins_o(cmd), .starts_o(starts), .stops_o(stops));
	// ----------------------------------------
	// Drivers, all on the falling edge
	// ----------------------------------------
	task run(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// Console strobes last one cycle; the wait lets any pulse run out
	task tap(input int k);
		con[k] = 1'b1;
		run(1);
		con = 4'h0;
		run(LEN + 6);
	endtask
	// Pins are held long enough to clear the two-stage synchroniser
	task push(input int k);
		press[k] = 1'b1;
		run(8);
		press = 5'h0;
		run(LEN + 6);
	endtask
	task conclude;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	// Watchdog: a hang counts as a mismatch
	initial
	begin
		run(20000);
		errors++;
		conclude();
	end
	initial
	begin
		{reset_n_i, prev, con, press, errors, compares} = '0;
		mode = PHG_ANS_NORMAL;
		run(16);
		reset_n_i = 1'b1;
		run(4);
		`CHK("off lamp", 1'b0, outp.off_lamp_oe_n)
		tap(0);
		`CHK("on lamp", 1'b0, outp.on_lamp_oe_n)
		`CHK("normal start", 0, starts)
		tap(1);
		tap(1);
		`CHK("stop once", 1, stops)
		mode = PHG_ANS_ON;
		push(4);
		`CHK("pin on", 1'b1, chan)
		`CHK("on answer", 1, starts)
		push(1);
		`CHK("reset pin", 1'b0, chan)
		`CHK("no stop", 1, stops)
		mode = PHG_ANS_ON_OR_LISTEN;
		push(2);
		`CHK("listen lamp", 1'b0, outp.listen_lamp_oe_n)
		`CHK("listen answer", 2, starts)
		tap(3);
		`CHK("listen off", 1'b1, outp.listen_lamp_oe_n)
		mode = PHG_ANS_NORMAL;
		prev = 1'b1;
		run(LEN + 6);
		prev = 1'b0;
		`CHK("preview start", 3, starts)
		tap(0);
		`CHK("lamp while on", 1'b1, outp.off_lamp_oe_n)
		press[0] = 1'b1;
		run(6);
		`CHK("ready lamp", 1'b0, outp.off_lamp_oe_n)
		press = 5'h0;
		tap(1);
		`CHK("second stop", 2, stops)
		conclude();
	end
endmodule
